// ---- quad_pot_params.svh ----
// timing, reset and encoding constants of the quad pot command decoder
`ifndef QUAD_POT_PARAMS_SVH
`define QUAD_POT_PARAMS_SVH

`define POT_COUNT          4
`define STORE_PER_POT      4
`define WIPER_RST_VAL      8'h00
`define NV_FILL_VAL        8'h80
`define FIRST_STORED_SETTING 2'h0

`define MCLK_PERIOD_NS     10
`define NV_PROG_MS         10
`define NV_PROG_CYC_CALC   (`NV_PROG_MS * 1000000 / `MCLK_PERIOD_NS)
`define NV_CNT_W           20

`define ACK_BIT_CNT        4'h8
`define LAST_DATA_BIT_CNT  4'h7

`define OP_RD_WIPER        4'h9
`define OP_WR_WIPER        4'ha
`define OP_RD_STORE        4'hb
`define OP_WR_STORE        4'hc
`define OP_RECALL          4'hd
`define OP_SAVE            4'he
`define OP_GANG_RECALL     4'h1
`define OP_GANG_SAVE       4'h8
`define OP_STEP            4'h2

`endif

// ---- quad_pot_pkg.sv ----
// types shared by the quad pot command decoder
package quad_pot_pkg;

   typedef logic [7:0] wiper_t;

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_INSTR,
      ST_WDATA,
      ST_RDATA,
      ST_STEP,
      ST_IGNORE
   } link_state_t;

   typedef struct packed
   {
      logic [3:0] opcodeBits;
      logic [1:0] dataRegSelectBits;
      logic [1:0] potSelectBits;
   } instr_t;

   typedef enum logic [1:0]
   {
      NV_NONE,
      NV_WRITE,
      NV_SAVE,
      NV_GANG_SAVE
   } nv_kind_t;

   typedef struct packed
   {
      nv_kind_t   kind;
      logic [1:0] dataRegSelectBits;
      logic [1:0] potSelectBits;
      wiper_t     data;
   } nv_op_t;

endpackage : quad_pot_pkg

// ---- sync2.sv ----
// two-flop synchroniser for pins entering the mclk domain
`timescale 1ns/10ps
module sync2 #(
   parameter int WIDTH = 1
)
(
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;

   // meta_q is read by dout only
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= '0;
         dout   <= '0;
      end
      else if (ce)
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule : sync2

// ---- scl_bit_capture.sv ----
// captures sda on each rising scl edge in the link clock domain
`timescale 1ns/10ps
module scl_bit_capture
(
   input  wire logic sclLink,
   input  wire logic rst_b,
   input  wire logic sdaIn,
   output logic      bitVal_q,
   output logic      bitTgl_q
);

   // value holds a full scl period, so the toggle qualifies it safely
   always_ff @(posedge sclLink or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bitVal_q <= 1'b0;
         bitTgl_q <= 1'b0;
      end
      else
      begin
         bitVal_q <= sdaIn;
         bitTgl_q <= ~bitTgl_q;
      end
   end

endmodule : scl_bit_capture

// ---- quad_pot_i2c_command_decoder.sv ----
// serial command decoder, wiper and stored setting registers of a quad pot
`timescale 1ns/10ps
`include "quad_pot_params.svh"

// Functional notes
// [R1] stepping starts after acknowledged step instruction
// [R2] sda high while scl high: step up
// [R3] sda low while scl high: step down
// [R4] read wiper: ack, return byte, msb first
// [R5] write wiper: ack all, load wiper
// [R6] read stored setting, return byte msb first
// [R7] write stored setting with one data byte
// [R8] gang recall loads all wipers
// [R9] gang save stores all wipers
// [R10] single save stores one wiper
// [R11] single recall loads one wiper
// [R12] stepping frame ends with stop
// [R13] programming starts only after stop
// [R14] respond only to matching address
// [R15] programming done within ten milliseconds
// [R16] reset recalls first stored setting
// [R17] wiper decoded to one-hot tap
// [R18] stepping saturates at both ends
// [R19] stop ends stepping, returns idle
// [R20] no address ack while programming
module quad_pot_i2c_command_decoder
   import quad_pot_pkg::*;
#(
   parameter logic [3:0]  DEV_TYPE       = 4'h6, // arbitrary value
   parameter int unsigned NV_PROG_CYCLES = `NV_PROG_CYC_CALC
)
(
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire logic                        ce,
   input  wire logic                        scl,
   input  wire logic                        sdaIn,
   output logic                             sdaOut,
   output logic                             sdaOeN,
   input  wire logic [3:0]                  addressSelectInputs,
   output wiper_t    [`POT_COUNT-1:0]       wiperPos,
   output logic      [`POT_COUNT-1:0][255:0] tapSel,
   output logic                             nvBusy,
   output logic                             stepActive
);

   logic        bitVal;
   logic        bitTgl;
   logic [2:0]  pinSync;
   logic [3:0]  addrSel;
   logic        sclS;
   logic        sdaS;
   logic        tglS;
   logic        sclPrev_q;
   logic        sdaPrev_q;
   logic        tglPrev_q;
   logic        startEv;
   logic        stopEv;
   logic        sclFallEv;
   logic        bitEv;
   logic        byteDone;
   logic        stepEn;

   link_state_t state_q;
   link_state_t pend_q;
   link_state_t pendD;
   logic [3:0]  bitCnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  byteIn;
   logic        ackPend_q;
   logic        ackD;
   logic        drvLow_q;
   instr_t      instr_q;
   instr_t      instrIn;
   wiper_t      tx_q;
   wiper_t      txD;

   wiper_t      wiperPositionReg_q [`POT_COUNT];
   wiper_t      storedSettingReg_q [`POT_COUNT][`STORE_PER_POT];
   logic [`POT_COUNT-1:0] wipLoadEn;
   wiper_t      wipLoadVal [`POT_COUNT];
   logic        recallPending_q;

   nv_op_t      nvReqD;
   logic        nvReqEn;
   nv_op_t      nvPend_q;
   logic [`NV_CNT_W-1:0] nvCnt_q;
   logic        nvBusy_q;

   // link domain: bit capture on the master's own clock
   scl_bit_capture uCapture
   (
      .sclLink  (scl),
      .rst_b    (rst_b),
      .sdaIn    (sdaIn),
      .bitVal_q (bitVal),
      .bitTgl_q (bitTgl)
   );

   sync2 #(.WIDTH(3)) uPinSync
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .din   ({scl, sdaIn, bitTgl}),
      .dout  (pinSync)
   );

   sync2 #(.WIDTH(4)) uAddrSync
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .din   (addressSelectInputs),
      .dout  (addrSel)
   );

   assign sclS = pinSync[2];
   assign sdaS = pinSync[1];
   assign tglS = pinSync[0];

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // match the synchroniser reset so no false edge follows reset
         sclPrev_q <= 1'b0;
         sdaPrev_q <= 1'b0;
         tglPrev_q <= 1'b0;
      end
      else if (ce)
      begin
         sclPrev_q <= sclS;
         sdaPrev_q <= sdaS;
         tglPrev_q <= tglS;
      end
   end

   // bus conditions seen by oversampling both lines
   assign startEv   = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
   assign stopEv    = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
   assign sclFallEv = sclPrev_q & ~sclS;
   assign bitEv     = tglS ^ tglPrev_q;

   // bitVal is stable for a whole scl period after its toggle
   assign byteIn   = {shift_q[6:0], bitVal};
   assign instrIn  = instr_t'(byteIn);
   assign byteDone = bitEv && (bitCnt_q == `LAST_DATA_BIT_CNT)
                     && (state_q != ST_IDLE) && (state_q != ST_STEP);
   assign stepEn   = bitEv && (state_q == ST_STEP); // [R1]

   // byte decode: acknowledge, next phase, register actions
   always_comb
   begin
      ackD      = 1'b0;
      pendD     = ST_IGNORE;
      txD       = tx_q;
      nvReqEn   = 1'b0;
      nvReqD    = nvPend_q;
      wipLoadEn = '0;
      for (int p = 0; p < `POT_COUNT; p++)
      begin
         wipLoadVal[p] = wiperPositionReg_q[p];
      end
      if (byteDone)
      begin
         case (state_q)
            ST_ADDR:
            begin
               if ((byteIn[7:4] == DEV_TYPE) && (byteIn[3:0] == addrSel)
                   && !nvBusy_q) // [R14] [R20]
               begin
                  ackD  = 1'b1;
                  pendD = ST_INSTR;
               end
            end
            ST_INSTR:
            begin
               ackD = 1'b1;
               case (instrIn.opcodeBits)
                  `OP_RD_WIPER:
                  begin
                     txD   = wiperPositionReg_q[instrIn.potSelectBits]; // [R4]
                     pendD = ST_RDATA;
                  end
                  `OP_WR_WIPER:
                  begin
                     pendD = ST_WDATA; // [R5]
                  end
                  `OP_RD_STORE:
                  begin
                     txD   = storedSettingReg_q[instrIn.potSelectBits]
                                               [instrIn.dataRegSelectBits]; // [R6]
                     pendD = ST_RDATA;
                  end
                  `OP_WR_STORE:
                  begin
                     pendD = ST_WDATA; // [R7]
                  end
                  `OP_RECALL:
                  begin
                     wipLoadEn[instrIn.potSelectBits] = 1'b1; // [R11]
                     wipLoadVal[instrIn.potSelectBits] =
                        storedSettingReg_q[instrIn.potSelectBits]
                                          [instrIn.dataRegSelectBits];
                  end
                  `OP_SAVE:
                  begin
                     nvReqEn = 1'b1; // [R10]
                     nvReqD  = '{NV_SAVE, instrIn.dataRegSelectBits,
                                 instrIn.potSelectBits, 8'h00};
                  end
                  `OP_GANG_RECALL:
                  begin
                     for (int p = 0; p < `POT_COUNT; p++)
                     begin
                        wipLoadEn[p]  = 1'b1; // [R8]
                        wipLoadVal[p] =
                           storedSettingReg_q[p][instrIn.dataRegSelectBits];
                     end
                  end
                  `OP_GANG_SAVE:
                  begin
                     nvReqEn = 1'b1; // [R9]
                     nvReqD  = '{NV_GANG_SAVE, instrIn.dataRegSelectBits,
                                 2'h0, 8'h00};
                  end
                  `OP_STEP:
                  begin
                     pendD = ST_STEP; // [R1] [R12]
                  end
                  default:
                  begin
                     ackD = 1'b0;
                  end
               endcase
            end
            ST_WDATA:
            begin
               ackD = 1'b1;
               if (instr_q.opcodeBits == `OP_WR_WIPER)
               begin
                  wipLoadEn[instr_q.potSelectBits]  = 1'b1; // [R5]
                  wipLoadVal[instr_q.potSelectBits] = byteIn;
               end
               else
               begin
                  nvReqEn = 1'b1; // [R7]
                  nvReqD  = '{NV_WRITE, instr_q.dataRegSelectBits,
                              instr_q.potSelectBits, byteIn};
               end
            end
            default:
            begin
               ackD = 1'b0;
            end
         endcase
      end
   end

   // frame sequencing
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q   <= ST_IDLE;
         pend_q    <= ST_IDLE;
         bitCnt_q  <= 4'h0;
         shift_q   <= 8'h00;
         ackPend_q <= 1'b0;
         instr_q   <= '0;
         tx_q      <= 8'h00;
      end
      else if (ce)
      begin
         if (startEv)
         begin
            state_q   <= ST_ADDR;
            bitCnt_q  <= 4'h0;
            ackPend_q <= 1'b0;
         end
         else if (stopEv)
         begin
            state_q   <= ST_IDLE; // [R19]
            bitCnt_q  <= 4'h0;
            ackPend_q <= 1'b0;
         end
         else if (bitEv && (state_q != ST_IDLE) && (state_q != ST_STEP))
         begin
            if (bitCnt_q == `ACK_BIT_CNT)
            begin
               // phase changes only after the acknowledge clock
               bitCnt_q  <= 4'h0;
               state_q   <= pend_q;
               ackPend_q <= 1'b0;
            end
            else
            begin
               shift_q  <= byteIn;
               bitCnt_q <= bitCnt_q + 4'h1;
               if (byteDone)
               begin
                  ackPend_q <= ackD;
                  pend_q    <= pendD;
                  tx_q      <= txD;
                  if (state_q == ST_INSTR)
                  begin
                     instr_q <= instrIn;
                  end
               end
            end
         end
      end
   end

   // sda changes only while scl is low
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         drvLow_q <= 1'b0;
      end
      else if (ce)
      begin
         if (startEv || stopEv)
         begin
            drvLow_q <= 1'b0;
         end
         else if (sclFallEv)
         begin
            if (bitCnt_q == `ACK_BIT_CNT)
            begin
               drvLow_q <= ackPend_q;
            end
            else if (state_q == ST_RDATA)
            begin
               drvLow_q <= ~tx_q[~bitCnt_q[2:0]]; // [R4] [R6]
            end
            else
            begin
               drvLow_q <= 1'b0;
            end
         end
      end
   end

   // wiper registers: recall at reset, loads, then stepping
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         recallPending_q <= 1'b1;
         for (int p = 0; p < `POT_COUNT; p++)
         begin
            wiperPositionReg_q[p] <= `WIPER_RST_VAL;
         end
      end
      else if (ce)
      begin
         recallPending_q <= 1'b0;
         for (int p = 0; p < `POT_COUNT; p++)
         begin
            if (recallPending_q)
            begin
               wiperPositionReg_q[p] <=
                  storedSettingReg_q[p][`FIRST_STORED_SETTING]; // [R16]
            end
            else if (wipLoadEn[p])
            begin
               wiperPositionReg_q[p] <= wipLoadVal[p];
            end
            else if (stepEn && (instr_q.potSelectBits == 2'(p)))
            begin
               if (bitVal && (wiperPositionReg_q[p] != 8'hff)) // [R18]
               begin
                  wiperPositionReg_q[p] <= wiperPositionReg_q[p] + 8'h01; // [R2]
               end
               else if (!bitVal && (wiperPositionReg_q[p] != 8'h00)) // [R18]
               begin
                  wiperPositionReg_q[p] <= wiperPositionReg_q[p] - 8'h01; // [R3]
               end
            end
         end
      end
   end

   // pending store is cancelled by a new start, committed by stop
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         nvPend_q <= '{NV_NONE, 2'h0, 2'h0, 8'h00};
      end
      else if (ce)
      begin
         if (startEv || stopEv)
         begin
            nvPend_q.kind <= NV_NONE;
         end
         else if (nvReqEn)
         begin
            nvPend_q <= nvReqD;
         end
      end
   end

   // stored settings: array write at stop, then busy window
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int p = 0; p < `POT_COUNT; p++)
         begin
            for (int s = 0; s < `STORE_PER_POT; s++)
            begin
               storedSettingReg_q[p][s] <= `NV_FILL_VAL;
            end
         end
      end
      else if (ce && stopEv && !nvBusy_q) // [R13]
      begin
         case (nvPend_q.kind)
            NV_WRITE:
            begin
               storedSettingReg_q[nvPend_q.potSelectBits]
                                 [nvPend_q.dataRegSelectBits] <= nvPend_q.data;
            end
            NV_SAVE:
            begin
               storedSettingReg_q[nvPend_q.potSelectBits]
                                 [nvPend_q.dataRegSelectBits] <=
                  wiperPositionReg_q[nvPend_q.potSelectBits];
            end
            NV_GANG_SAVE:
            begin
               for (int p = 0; p < `POT_COUNT; p++)
               begin
                  storedSettingReg_q[p][nvPend_q.dataRegSelectBits] <=
                     wiperPositionReg_q[p];
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         nvBusy_q <= 1'b0;
         nvCnt_q  <= '0;
      end
      else if (ce)
      begin
         if (stopEv && !nvBusy_q && (nvPend_q.kind != NV_NONE)) // [R13]
         begin
            nvBusy_q <= 1'b1;
            nvCnt_q  <= '0;
         end
         else if (nvBusy_q)
         begin
            if (nvCnt_q == `NV_CNT_W'(NV_PROG_CYCLES - 1)) // [R15]
            begin
               nvBusy_q <= 1'b0;
            end
            nvCnt_q <= nvCnt_q + `NV_CNT_W'(1);
         end
      end
   end

   // one-hot tap decode, registered
   for (genvar p = 0; p < `POT_COUNT; p++)
   begin : g_tap
      always_ff @(posedge mclk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            tapSel[p] <= 256'h1;
         end
         else if (ce)
         begin
            tapSel[p] <= 256'h1 << wiperPositionReg_q[p]; // [R17]
         end
      end
      assign wiperPos[p] = wiperPositionReg_q[p];
   end

   assign sdaOut     = 1'b0;
   assign sdaOeN     = ~drvLow_q;
   assign nvBusy     = nvBusy_q;
   assign stepActive = (state_q == ST_STEP);

endmodule : quad_pot_i2c_command_decoder

// ---- quad_pot_assertions.sv ----
// concurrent checks on the quad pot decoder ports
`timescale 1ns/10ps
`include "quad_pot_params.svh"
module quad_pot_assertions
   import quad_pot_pkg::*;
#(
   parameter int unsigned NV_PROG_CYCLES = 50
)
(
   input wire logic                         mclk,
   input wire logic                         rst_b,
   input wire logic                         ce,
   input wire logic                         scl,
   input wire logic                         sdaIn,
   input wire logic                         sdaOut,
   input wire logic                         sdaOeN,
   input wire logic [3:0]                   addressSelectInputs,
   input wire wiper_t [`POT_COUNT-1:0]      wiperPos,
   input wire logic [`POT_COUNT-1:0][255:0] tapSel,
   input wire logic                         nvBusy,
   input wire logic                         stepActive
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic        sclP_q, sdaP_q, stopSeen;
   logic [7:0]  stopAge_q, ackAge_q;
   int unsigned busyRun_q;
   // raw pins: stop is seen before the design's own synchroniser
   assign stopSeen = scl && sclP_q && sdaIn && !sdaP_q;
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         {sclP_q, sdaP_q} <= 2'b11;
      else
         {sclP_q, sdaP_q} <= {scl, sdaIn};
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         stopAge_q <= 8'hff;
      else if (stopSeen)
         stopAge_q <= 8'h00;
      else if (stopAge_q != 8'hff)
         stopAge_q <= stopAge_q + 8'h01;
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         ackAge_q <= 8'hff;
      else if (!sdaOeN)
         ackAge_q <= 8'h00;
      else if (ackAge_q != 8'hff)
         ackAge_q <= ackAge_q + 8'h01;
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         busyRun_q <= 0;
      else if (ce)
         busyRun_q <= nvBusy ? busyRun_q + 1 : 0;
   for (genvar p = 0; p < `POT_COUNT; p++)
   begin : g_pot
      chk_tap_follow: assert property (
         tapSel[p] == (256'h1 << $past(wiperPos[p])))
         else $error("tap select does not follow wiper");
      chk_step_nowrap: assert property (
         stepActive && $past(stepActive) |->
         !($past(wiperPos[p]) == 8'hff && wiperPos[p] == 8'h00) &&
         !($past(wiperPos[p]) == 8'h00 && wiperPos[p] == 8'hff))
         else $error("wiper wrapped while stepping");
      chk_step_one: assert property (
         stepActive && $past(stepActive) && $changed(wiperPos[p]) |->
         wiperPos[p] == 8'($past(wiperPos[p]) + 8'h01) ||
         wiperPos[p] == 8'($past(wiperPos[p]) - 8'h01))
         else $error("step moved wiper by more than one tap");
   end
   chk_stop_release: assert property (
      stopSeen |-> ##[1:6] (sdaOeN && !stepActive))
      else $error("stop did not end the frame");
   chk_busy_bound: assert property (busyRun_q <= NV_PROG_CYCLES)
      else $error("programming window too long");
   chk_busy_cause: assert property ($rose(nvBusy) |-> stopAge_q <= 8)
      else $error("programming began without a stop");
   chk_busy_noack: assert property (nvBusy |-> sdaOeN)
      else $error("data line driven while programming");
   chk_step_acked: assert property (
      $rose(stepActive) |-> (ackAge_q <= 40) or (##[0:12] !sdaOeN))
      else $error("stepping entered without acknowledge");
   chk_ack_slot: assert property (
      $fell(sdaOeN) |-> !scl && !$past(scl, 2))
      else $error("data line driven while clock high");
endmodule : quad_pot_assertions

bind quad_pot_i2c_command_decoder quad_pot_assertions #(
   .NV_PROG_CYCLES(NV_PROG_CYCLES)
) quad_pot_assertions_inst (
   .mclk(mclk), .rst_b(rst_b), .ce(ce), .scl(scl), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOeN(sdaOeN),
   .addressSelectInputs(addressSelectInputs), .wiperPos(wiperPos),
   .tapSel(tapSel), .nvBusy(nvBusy), .stepActive(stepActive)
);

// ---- bus_master.sv ----
// serial bus master model driving the clock and data wire
`timescale 1ns/10ps
module bus_master
(
   input  wire logic sdaWire,
   output logic      scl,
   output logic      sdaM
);
   initial
   begin
      scl  = 1'b1;
      sdaM = 1'b1;
   end
   // clock idles high between frames
   task automatic start();
      sdaM = 1'b1;
      #40 scl = 1'b1;
      #80 sdaM = 1'b0;
      #80 scl = 1'b0;
      #40;
   endtask : start
   task automatic stop();
      sdaM = 1'b0;
      #40 scl = 1'b1;
      #80 sdaM = 1'b1;
      #80;
   endtask : stop
   task automatic clk(input logic b, output logic s);
      sdaM = b;
      #40 scl = 1'b1;
      #80 s = sdaWire;
      scl = 1'b0;
      #40;
   endtask : clk
   // ninth clock released so the device can answer
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clk(tx[i], s);
         rx[i] = s;
      end
      clk(1'b1, s);
      ack = ~s;
   endtask : xfer
endmodule : bus_master

// ---- quad_pot_i2c_command_decoder_test.sv ----
// self-checking bench for the quad pot command decoder
`timescale 1ns/10ps
`include "quad_pot_params.svh"
module quad_pot_i2c_command_decoder_test;
   import quad_pot_pkg::*;
   localparam int         NV  = 300;
   localparam logic [3:0] DEV = 4'h6; // arbitrary value
   logic                         mclk, rst_b, ce, scl, sdaM, sdaIn, s;
   logic                         sdaOut, sdaOeN, nvBusy, stepActive, ack;
   logic [3:0]                   addressSelectInputs;
   wiper_t [`POT_COUNT-1:0]      wiperPos, w, nw, g;
   logic [`POT_COUNT-1:0][255:0] tapSel;
   logic [31:0]                  expQ[$];
   logic [7:0]                   rx, v, me;
   logic [1:0]                   p, r;
   int                           fails, total_checks, busyCnt, b0;

   assign sdaIn = sdaM & (sdaOeN | sdaOut);
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) busyCnt <= busyCnt + int'(nvBusy === 1'b1);
   always @(wiperPos)
      if (rst_b === 1'b1)
         check(wiperPos, expQ.size() > 0 ? expQ.pop_front() : 'x);

   quad_pot_i2c_command_decoder #(
      .DEV_TYPE(DEV), .NV_PROG_CYCLES(NV)
   ) quad_pot_i2c_command_decoder_inst (
      .mclk(mclk), .rst_b(rst_b), .ce(ce), .scl(scl), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .addressSelectInputs(addressSelectInputs), .wiperPos(wiperPos),
      .tapSel(tapSel), .nvBusy(nvBusy), .stepActive(stepActive)
   );
   bus_master bus_master_inst (.sdaWire(sdaIn), .scl(scl), .sdaM(sdaM));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic want(input wiper_t [`POT_COUNT-1:0] x);
      if (x !== w)
         expQ.push_back(x);
      w = x;
   endtask : want
   task automatic cmd(input logic [7:0] ad, input logic [7:0] ins,
                      input logic [7:0] d, input int n,
                      input logic aok, input logic st);
      bus_master_inst.start();
      bus_master_inst.xfer(ad, rx, ack);
      check(ack, aok);
      if (aok)
      begin
         bus_master_inst.xfer(ins, rx, ack);
         check(ack, 1'b1);
         if (n > 0)
            bus_master_inst.xfer(n == 2 ? 8'hff : d, rx, ack);
         if (n == 1)
            check(ack, 1'b1);
      end
      if (st)
         bus_master_inst.stop();
   endtask : cmd
   task automatic wr(input logic [7:0] x);
      nw = w;
      nw[p] = x;
      want(nw);
      cmd(me, {4'ha, 2'b00, p}, x, 1, 1'b1, 1'b1);
   endtask : wr
   task automatic step(input logic up, input int n);
      repeat (n)
      begin
         nw = w;
         if (up && w[p] != 8'hff)
            nw[p] = w[p] + 8'h01;
         if (!up && w[p] != 8'h00)
            nw[p] = w[p] - 8'h01;
         want(nw);
         bus_master_inst.clk(up, s);
      end
   endtask : step
   task automatic waitIdle();
      int i;
      i = 0;
      while (nvBusy !== 1'b0 && i < 1000)
      begin
         @(negedge mclk);
         i++;
      end
      if (i == 1000)
      begin
         fails++;
         conclude();
      end
      #3;
   endtask : waitIdle
   task automatic conclude();
      check(expQ.size(), 0);
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   initial
   begin
      rst_b = 1'b0;
      ce = 1'b1;
      addressSelectInputs = 4'h0;
      {fails, total_checks} = '0;
      v = 8'($urandom(90));
      repeat (10) @(negedge mclk);
      addressSelectInputs = 4'($urandom);
      me = {DEV, addressSelectInputs};
      w = {`POT_COUNT{`NV_FILL_VAL}};
      expQ.push_back(w);
      rst_b = 1'b1;
      repeat (8) @(negedge mclk);
      #3;
      cmd({DEV, ~me[3:0]}, 8'h90, 8'h00, 0, 1'b0, 1'b1);
      cmd({~DEV, me[3:0]}, 8'h90, 8'h00, 0, 1'b0, 1'b1);
      for (int q = 0; q < `POT_COUNT; q++)
      begin
         p = 2'(q);
         wr(8'($urandom));
         cmd(me, {4'h9, 2'b00, p}, 8'h00, 2, 1'b1, 1'b1);
         check(rx, w[p]);
         check(tapSel[q] === (256'h1 << w[q]), 1'b1);
      end
      p = 2'($urandom);
      r = 2'($urandom);
      v = 8'($urandom);
      b0 = busyCnt;
      cmd(me, {4'hc, r, p}, v, 1, 1'b1, 1'b0);
      check(busyCnt - b0, 0);
      bus_master_inst.stop();
      cmd(me, 8'h90, 8'h00, 0, 1'b0, 1'b1);
      // ce low freezes the programming counter, so the busy window stretches
      @(negedge mclk) ce = 1'b0;
      repeat (20) @(negedge mclk);
      ce = 1'b1;
      waitIdle();
      check(busyCnt - b0, NV + 20);
      cmd(me, {4'hb, r, p}, 8'h00, 2, 1'b1, 1'b1);
      check(rx, v);
      v = w[p];
      cmd(me, {4'he, 2'h2, p}, 8'h00, 0, 1'b1, 1'b1);
      waitIdle();
      wr(~v);
      nw = w;
      nw[p] = v;
      want(nw);
      cmd(me, {4'hd, 2'h2, p}, 8'h00, 0, 1'b1, 1'b1);
      g = w;
      cmd(me, {4'h8, 2'h3, 2'b00}, 8'h00, 0, 1'b1, 1'b1);
      waitIdle();
      for (int q = 0; q < `POT_COUNT; q++)
      begin
         p = 2'(q);
         wr(~g[q]);
      end
      want(g);
      cmd(me, {4'h1, 2'h3, 2'b00}, 8'h00, 0, 1'b1, 1'b1);
      p = 2'h1;
      wr(8'hfe);
      cmd(me, 8'h21, 8'h00, 0, 1'b1, 1'b0);
      step(1'b1, 1);
      check(stepActive, 1'b1);
      step(1'b0, 1);
      step(1'b1, 2);
      // repeated start clocks sda high: a no-op at the top tap
      wr(8'h02);
      cmd(me, 8'h21, 8'h00, 0, 1'b1, 1'b0);
      step(1'b1, 1);
      step(1'b0, 5);
      bus_master_inst.stop();
      repeat (6) @(negedge mclk);
      check(stepActive, 1'b0);
      #100;
      conclude();
   end
endmodule : quad_pot_i2c_command_decoder_test
